// ===== hdl/waveform_gen_config_shutdown.v
// Purpose: Steering, auto-shutdown and rising dead-band of a waveform generator
// Assumes: All source inputs and the fast oscillator are asynchronous to pclk
// Notes:   APB slave with zero wait states; outputs tri-state via active-low enables
`timescale 1ns/1ps
`include "wavegen_map.vh"

// Functional notes
// - Clock select bit picks system or fast oscillator
// - Four-bit code picks waveform input; 1110/1111 reserved
// - Steer enable one: output carries polarity-adjusted data
// - Steer enable zero: output carries its override bit
// - Steering bits act only in modes 00x
// - Steer enables double-buffered in synchronous steering mode
// - Shutdown status set by hardware, also software-writable
// - Software shutdown while disabled applies shutdown levels
// - After clear, hold levels until data rising edge
// - Restart enable picks automatic or software restart
// - Auto restart clears status when conditions vanish
// - Software clear ignored while condition present
// - B/D level field: high, low, tri-state, inactive
// - A/C level field uses the same four codes
// - Five enables select pin, comparators, cells as sources
// - Rise dead-band n delays n to n+1 clocks
// - Zero dead-band count bypasses the delay
// - Unimplemented bits read zero, writes ignored
module waveform_gen_config_shutdown (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        remapped_pin_input,
    input  wire [12:0] source_inputs,
    input  wire        internal_fast_osc,
    output wire [3:0]  out_level,
    output wire [3:0]  out_enable_n
);

    // Control registers
    reg        enable_q;            // Module enable
    reg [2:0]  mode_q;              // Output mode field
    reg [3:0]  invert_q;            // Per-output polarity, A in bit 0
    reg        gen_clock_pick_q;    // Generator clock choice
    reg [3:0]  waveform_source_q;   // Data source code
    reg [3:0]  override_level_q;    // Steering data bits
    reg [3:0]  steer_enable_q;      // Written steering enables
    reg [3:0]  steer_live_q;        // Steering enables in force
    reg        shutdown_q;          // Shutdown status
    reg        restart_en_q;        // Auto restart enable
    reg [1:0]  halt_level_bd_q;     // Shutdown level for B and D
    reg [1:0]  halt_level_ac_q;     // Shutdown level for A and C
    reg [4:0]  halt_src_en_q;       // Shutdown source enables
    reg [5:0]  rise_deadtime_q;     // Rising dead-band count
    reg        hold_q;              // Outputs held at shutdown levels

    // Synchroniser stages
    reg [`SRC_COUNT-1:0] src_meta_q;    // First stage, read only by second
    reg [`SRC_COUNT-1:0] src_sync_q;    // Second stage
    reg                  osc_meta_q;    // First stage of fast oscillator
    reg                  osc_sync_q;    // Second stage of fast oscillator
    reg                  osc_prev_q;    // Previous oscillator level

    // Datapath state
    reg        data_prev_q;         // Selected data, one cycle back
    reg [5:0]  db_count_q;          // Dead-band ticks elapsed
    reg        db_out_q;            // Data after rising dead-band
    reg [3:0]  level_q;             // Output levels
    reg [3:0]  enable_n_q;          // Output enables, low drives

    wire [`SRC_COUNT-1:0] src_raw;  // All asynchronous sources
    wire                  waveform_source_value;
    wire                  data_rise;
    wire                  gen_tick;
    wire                  halt_cond;
    wire                  steer_mode;
    wire                  halted;
    wire [4:0]            halt_sources;

    // APB decode terms
    wire        setup_phase;
    wire        wr_commit;
    wire [31:0] wdata;
    reg  [7:0]  rd_byte;            // Read value of addressed register
    reg         rd_hit;             // Address is mapped

    // Source vector, pin input at bit 0
    // Only the low write byte is used
    assign src_raw = {source_inputs, remapped_pin_input};
    assign wdata   = pwdata;

    // Two-flop synchronisers, one per source
    // Sources are free-running levels;
    // the first stage may go metastable
    genvar s;
    generate
        for (s = 0; s < `SRC_COUNT; s = s + 1) begin : g_sync
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    src_meta_q[s] <= 1'b0;
                    src_sync_q[s] <= 1'b0;
                end else begin
                    src_meta_q[s] <= src_raw[s];
                    src_sync_q[s] <= src_meta_q[s];
                end
            end
        end
    endgenerate

    // Third stage feeds the rise detector
    // Fast oscillator sampled into the bus clock domain
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_meta_q <= 1'b0;
            osc_sync_q <= 1'b0;
            osc_prev_q <= 1'b0;
        end else begin
            osc_meta_q <= internal_fast_osc;
            osc_sync_q <= osc_meta_q;
            osc_prev_q <= osc_sync_q;
        end
    end

    // Dead-band time base: every pclk, or each fast oscillator rise
    // Oscillator must stay below half of pclk
    // so that no rise is missed
    assign gen_tick = gen_clock_pick_q ? (osc_sync_q & ~osc_prev_q) : 1'b1;

    // Data source select; reserved codes give a quiet low
    assign waveform_source_value = (waveform_source_q < 4'hE) ?
                                   src_sync_q[waveform_source_q] : 1'b0;
    // One-cycle pulse on each data rise
    assign data_rise = waveform_source_value & ~data_prev_q;

    // Enabled shutdown sources, in enable bit order
    assign halt_sources = {src_sync_q[`SRC_CELL4], src_sync_q[`SRC_CELL2],
                           src_sync_q[`SRC_CMP2], src_sync_q[`SRC_CMP1],
                           src_sync_q[`SRC_PIN]};
    assign halt_cond  = |(halt_sources & halt_src_en_q);
    assign steer_mode = (mode_q[2:1] == 2'b00);
    // Mode 00x selects the steering modes
    // Held state counts only while enabled
    assign halted     = shutdown_q | (enable_q & hold_q);

    // APB phase terms; a write lands at the access edge with pready high
    assign setup_phase = psel & ~penable;
    // Same qualifier as the master's ready check
    assign wr_commit   = psel & penable & pwrite & pready;

    // Read mux and address decode
    always @* begin
        // Defaults keep the process latch-free
        rd_byte = 8'h00;
        rd_hit  = 1'b1;
        if (paddr == `OFS_MODE_CONTROL) begin
            rd_byte = {enable_q, 4'h0, mode_q};
        end else if (paddr == `OFS_POLARITY_CONTROL) begin
            rd_byte = {2'b00, waveform_source_value, 1'b0, invert_q};
        end else if (paddr == `OFS_CLOCK_SOURCE) begin
            rd_byte = {7'h00, gen_clock_pick_q};
        end else if (paddr == `OFS_DATA_INPUT) begin
            rd_byte = {4'h0, waveform_source_q};
        end else if (paddr == `OFS_STEERING) begin
            rd_byte = {override_level_q, steer_enable_q};
        end else if (paddr == `OFS_SHUTDOWN_CTRL0) begin
            rd_byte = {shutdown_q, restart_en_q, halt_level_bd_q,
                       halt_level_ac_q, 2'b00};
        end else if (paddr == `OFS_SHUTDOWN_SRC_EN) begin
            rd_byte = {3'h0, halt_src_en_q};
        end else if (paddr == `OFS_RISE_DEADBAND) begin
            rd_byte = {2'b00, rise_deadtime_q};
        end else begin
            // Unmapped or unaligned address
            rd_hit = 1'b0;
        end
    end

    // APB answer: ready one cycle after setup, data captured in setup
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            // Exactly one access cycle per setup
            pready <= setup_phase;
            if (setup_phase) begin
                prdata  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
                pslverr <= ~rd_hit;
            end else begin
                // Bus quiet outside the access cycle
                prdata  <= 32'h0000_0000;
                pslverr <= 1'b0;
            end
        end
    end

    // Plain read-write configuration registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_q          <= 1'b0;
            mode_q            <= 3'h0;
            invert_q          <= `RST_POLARITY;
            gen_clock_pick_q  <= `RST_CLOCK_SOURCE;
            waveform_source_q <= `RST_DATA_INPUT;
            override_level_q  <= 4'h0;
            steer_enable_q    <= 4'h0;
            restart_en_q      <= 1'b0;
            halt_level_bd_q   <= `RST_LEVEL_BD;
            halt_level_ac_q   <= `RST_LEVEL_AC;
            halt_src_en_q     <= `RST_SRC_EN;
            rise_deadtime_q   <= `RST_RISE_DEADBAND;
        // Writes land only at the access edge
        end else if (wr_commit) begin
            if (paddr == `OFS_MODE_CONTROL) begin
                enable_q <= wdata[`BIT_ENABLE];
                mode_q   <= wdata[2:0];
            end else if (paddr == `OFS_POLARITY_CONTROL) begin
                invert_q <= wdata[3:0];
            end else if (paddr == `OFS_CLOCK_SOURCE) begin
                // Only bit 0 is stored
                gen_clock_pick_q <= wdata[0];
            end else if (paddr == `OFS_DATA_INPUT) begin
                waveform_source_q <= wdata[3:0];
            end else if (paddr == `OFS_STEERING) begin
                // Override and enable halves
                override_level_q <= wdata[7:4];
                steer_enable_q   <= wdata[3:0];
            end else if (paddr == `OFS_SHUTDOWN_CTRL0) begin
                restart_en_q    <= wdata[`BIT_RESTART_EN];
                halt_level_bd_q <= wdata[`POS_LEVEL_BD +: 2];
                halt_level_ac_q <= wdata[`POS_LEVEL_AC +: 2];
            end else if (paddr == `OFS_SHUTDOWN_SRC_EN) begin
                // Bits 7:5 are not stored
                halt_src_en_q <= wdata[4:0];
            end else if (paddr == `OFS_RISE_DEADBAND) begin
                // Bits 7:6 are not stored
                rise_deadtime_q <= wdata[5:0];
            end
        end
    end

    // Shutdown status: hardware set wins over any clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shutdown_q <= 1'b0;
        end else if (halt_cond) begin
            shutdown_q <= 1'b1;
        end else if (wr_commit && paddr == `OFS_SHUTDOWN_CTRL0) begin
            // Accepted in any enable state; clear only with no condition
            shutdown_q <= wdata[`BIT_SHUTDOWN];
        end else if (restart_en_q) begin
            // Auto restart once no condition is left
            shutdown_q <= 1'b0;
        end
    end

    // Hold at shutdown levels until a data rise after the clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_q <= 1'b1;
        end else if (shutdown_q || !enable_q) begin
            hold_q <= 1'b1;
        end else if (data_rise) begin
            // Release only on a fresh data rise
            hold_q <= 1'b0;
        end
    end

    // Steering enables in force: direct or buffered to data rise
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            steer_live_q <= 4'h0;
        end else if (mode_q != `MODE_SYNC_STEER) begin
            // Outside sync mode a write acts at once
            steer_live_q <= steer_enable_q;
        end else if (data_rise) begin
            // Buffer moves to the pins on a data rise
            steer_live_q <= steer_enable_q;
        end
    end

    // Rising dead-band: delay the rise, pass the fall at once
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_prev_q <= 1'b0;
            db_count_q  <= 6'h00;
            db_out_q    <= 1'b0;
        end else begin
            // Edge history for the rise detector
            data_prev_q <= waveform_source_value;
            // A fall cuts any pending delay short
            if (!waveform_source_value) begin
                db_count_q <= 6'h00;
                db_out_q   <= 1'b0;
            end else if (rise_deadtime_q == 6'h00) begin
                db_out_q <= 1'b1;
            end else if (!db_out_q && gen_tick) begin
                // Rise on the tick after n counted ticks
                if (db_count_q == rise_deadtime_q) begin
                    db_out_q <= 1'b1;
                end else begin
                    db_count_q <= db_count_q + 6'h01;
                end
            end
        end
    end

    // Per-output level and enable
    genvar c;
    generate
        for (c = 0; c < 4; c = c + 1) begin : g_out
            wire [1:0] lvl;
            wire       normal;
            // A and C take the A/C field, B and D the B/D field
            assign lvl = (c % 2 == 0) ? halt_level_ac_q : halt_level_bd_q;
            assign normal = steer_mode ?
                (steer_live_q[c] ? (db_out_q ^ invert_q[c])
                                 : override_level_q[c])
                : invert_q[c];
            // Registered so each pin comes off a flop
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    level_q[c]    <= 1'b0;
                    enable_n_q[c] <= 1'b1;
                end else if (halted) begin
                    // Shutdown levels, also when forced while disabled
                    case (lvl)
                        `LVL_HIGH: begin
                            level_q[c]    <= 1'b1;
                            enable_n_q[c] <= 1'b0;
                        end
                        `LVL_LOW: begin
                            level_q[c]    <= 1'b0;
                            enable_n_q[c] <= 1'b0;
                        end
                        `LVL_TRISTATE: begin
                            level_q[c]    <= 1'b0;
                            enable_n_q[c] <= 1'b1;
                        end
                        // Inactive level, no dead-band wait
                        default: begin
                            level_q[c]    <= invert_q[c];
                            enable_n_q[c] <= 1'b0;
                        end
                    endcase
                end else if (!enable_q) begin
                    // Disabled and not shut down: release the pin
                    // Pin level is then left to the outside
                    level_q[c]    <= 1'b0;
                    enable_n_q[c] <= 1'b1;
                end else begin
                    // Normal drive from steering or mode
                    level_q[c]    <= normal;
                    enable_n_q[c] <= 1'b0;
                end
            end
        end
    endgenerate

    // Pins straight from the output flops
    assign out_level    = level_q;
    assign out_enable_n = enable_n_q;

endmodule // waveform_gen_config_shutdown

// ===== shared/wavegen_map.vh
// Purpose: Register map and field constants of the waveform generator
// Assumes: APB byte addresses, one 32-bit word per 8-bit register
// Notes:   Definitions only
`ifndef WAVEGEN_MAP_VH
`define WAVEGEN_MAP_VH

// Register byte offsets
`define OFS_MODE_CONTROL     8'h00
`define OFS_POLARITY_CONTROL 8'h04
`define OFS_CLOCK_SOURCE     8'h08
`define OFS_DATA_INPUT       8'h0C
`define OFS_STEERING         8'h10
`define OFS_SHUTDOWN_CTRL0   8'h14
`define OFS_SHUTDOWN_SRC_EN  8'h18
`define OFS_RISE_DEADBAND    8'h1C

// Mode control fields
`define BIT_ENABLE           7
`define MODE_ASYNC_STEER     3'h0
`define MODE_SYNC_STEER      3'h1

// Polarity control fields
`define BIT_DATA_IN_RO       5

// Shutdown control 0 fields
`define BIT_SHUTDOWN         7
`define BIT_RESTART_EN       6
`define POS_LEVEL_BD         4
`define POS_LEVEL_AC         2

// Shutdown level codes
`define LVL_HIGH             2'h3
`define LVL_LOW              2'h2
`define LVL_TRISTATE         2'h1
`define LVL_INACTIVE         2'h0

// Shutdown source positions in the synchronised source vector
`define SRC_PIN              0
`define SRC_CMP1             1
`define SRC_CMP2             2
`define SRC_CELL2            11
`define SRC_CELL4            13

// Number of data source codes in use
`define SRC_COUNT            14

// Reset values
`define RST_MODE_CONTROL     8'h00
`define RST_POLARITY         4'h0
`define RST_CLOCK_SOURCE     1'h0
`define RST_DATA_INPUT       4'h0
`define RST_STEERING         8'h00
`define RST_LEVEL_BD         2'h1
`define RST_LEVEL_AC         2'h1
`define RST_SRC_EN           5'h00
`define RST_RISE_DEADBAND    6'h00

`endif

// ===== dv/wavegen_chk.sv
// Purpose: Concurrent checks on the bus and output pins of the waveform generator
// Assumes: Single pclk domain, asynchronous active-low reset
// Notes:   Bound to the top module from the testbench file
`timescale 1ns/1ps
module wavegen_chk (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire [7:0]  paddr,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire [3:0]  out_enable_n
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Answer follows every setup cycle at once
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("ready missing after setup cycle");
    // Ready only inside an access phase
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("ready outside access phase");
    // Ready stands for exactly one cycle
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    a_error_with_ready: assert property (pslverr |-> pready)
        else $error("error flag without ready");
    a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0)
        else $error("read data not zero outside access");
    a_upper_bits_zero: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("unimplemented read bits not zero");
    a_unmapped_error: assert property (psel && !penable && paddr > 8'h1C |=> pslverr)
        else $error("unmapped access not refused");
    a_mapped_no_error: assert property (
        psel && !penable && paddr <= 8'h1C && paddr[1:0] == 2'b00 |=> !pslverr)
        else $error("mapped access refused");
    // Output flops reset with enables high and the module disabled, so pins start released
    a_reset_released: assert property ($rose(presetn) |-> out_enable_n == 4'hF)
        else $error("outputs driven right after reset");
endmodule // wavegen_chk

// ===== dv/source_model.sv
// Purpose: Far-side model of the on-chip signal sources
// Assumes: Sources are plain logic levels, fast oscillator runs free
// Notes:   Data wave on the picked line, fault levels on the shutdown lines
`timescale 1ns/1ps
module source_model (
    input  wire logic        pclk,
    input  wire logic [3:0]  code,
    input  wire logic        run,
    input  wire logic [4:0]  fault,
    output logic             remapped_pin_input,
    output logic [12:0]      source_inputs,
    output logic             internal_fast_osc,
    output logic             wave
);
    logic [5:0]  cnt = 6'h00;    // Wave phase counter
    logic [13:0] lines;          // Line k carries data code k
    initial internal_fast_osc = 1'b0;
    initial wave = 1'b0;
    // Free-running fast oscillator, 12 ns period
    always #6 internal_fast_osc = ~internal_fast_osc;
    // Square wave of 64 pclk periods, held low while stopped
    always @(posedge pclk) begin
        cnt <= run ? cnt + 6'h01 : 6'h00;
        wave <= run & cnt[5];
    end
    // Wave on the picked line, faults ORed onto shutdown lines
    always_comb begin
        lines = 14'h0000;
        if (code < 4'hE)
            lines[code] = wave;
        lines[0]  = lines[0] | fault[0];
        lines[1]  = lines[1] | fault[1];
        lines[2]  = lines[2] | fault[2];
        lines[11] = lines[11] | fault[3];
        lines[13] = lines[13] | fault[4];
    end
    assign remapped_pin_input = lines[0];
    assign source_inputs      = lines[13:1];
endmodule // source_model

// ===== dv/waveform_gen_config_shutdown_test.sv
// Purpose: Self-checking bench for the waveform generator control block
// Assumes: Zero-wait APB slave, sources driven by source_model
// Notes:   Stimulus changes by non-blocking assignment at the rising edge
`timescale 1ns/1ps
`include "wavegen_map.vh"
module waveform_gen_config_shutdown_test;
    logic        pclk = 0;
    logic        presetn = 0;
    logic        psel = 0;
    logic        penable = 0;
    logic        pwrite = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0;
    logic [31:0] prdata, r;
    logic        pready, pslverr, pin, fosc, wave, perr;
    logic [12:0] srcs;
    logic [3:0]  out_level, out_enable_n, en, lv;
    logic [3:0]  code = 0;       // Source line carrying the wave
    logic        run = 0;        // Wave running
    logic [4:0]  fault = 0;      // Shutdown lines forced high
    logic [1:0]  bd, ac, c;
    logic [7:0]  cw;
    int          mismatches = 0, compares = 0, d0, d;

    always #2 pclk = ~pclk;      // 250 MHz

    waveform_gen_config_shutdown u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .remapped_pin_input(pin), .source_inputs(srcs),
        .internal_fast_osc(fosc), .out_level(out_level), .out_enable_n(out_enable_n));
    source_model u_src (.pclk(pclk), .code(code), .run(run), .fault(fault),
        .remapped_pin_input(pin), .source_inputs(srcs), .internal_fast_osc(fosc), .wave(wave));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("Counts: compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // One APB transfer, request held until ready is sampled
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        r = prdata;
        perr = pslverr;
        psel <= 0;
        penable <= 0;
        if (n >= 16) begin
            mismatches++;
            close_out();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        xfer(1'b1, a, {24'h0, v});
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        xfer(1'b0, a, 32'h0);
        chk(r, {24'h0, e});
    endtask
    // Wait for the wave to reach level lv fresh, then some cycles
    task automatic wedge(input logic lv, input int after);
        int n;
        n = 0;
        while (wave !== !lv && n < 200) begin
            @(posedge pclk);
            n++;
        end
        while (wave !== lv && n < 200) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 200) begin
            mismatches++;
            close_out();
        end
        repeat (after) @(posedge pclk);
    endtask
    // Enables and driven levels; released pins compare as zero
    task automatic ochk(input logic [3:0] e, input logic [3:0] l);
        chk({24'h0, out_enable_n, out_level & ~out_enable_n}, {24'h0, e, l & ~e});
    endtask
    // Cycles from wave rise to output A rise
    task automatic meas(output int dl);
        wedge(1'b1, 0);
        dl = 0;
        while (out_level[0] !== 1'b1 && dl < 100) begin
            @(posedge pclk);
            dl++;
        end
    endtask

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1;
        for (int a = 0; a < 8; a++) rd(8'(a * 4), (a == 5) ? 8'h14 : 8'h00);
        rd(8'h20, 8'h00);
        chk({31'h0, perr}, 32'h1);
        for (int a = 2; a < 8; a++) begin
            wr(8'(a * 4), 8'hFF);
            rd(8'(a * 4), (a == 2) ? 8'h01 : (a == 3) ? 8'h0F : (a == 4) ? 8'hFF :
               (a == 5) ? 8'h7C : (a == 6) ? 8'h1F : 8'h3F);
            wr(8'(a * 4), (a == 5) ? 8'h14 : 8'h00);
        end
        $display("test registers done");
        wr(`OFS_MODE_CONTROL, 8'h80);
        wr(`OFS_POLARITY_CONTROL, 8'h06);
        wr(`OFS_STEERING, 8'h0F);
        wr(`OFS_DATA_INPUT, 8'h03);
        code <= 3;
        for (int s = 0; s < 5; s++) begin
            bd = 2'(s % 4);
            ac = 2'((s + 2) % 4);
            cw = {1'b0, s == 4, bd, ac, 2'b00};
            for (int k = 0; k < 4; k++) begin
                c = k[0] ? bd : ac;
                en[k] = (c == 2'h1);
                lv[k] = (c == 2'h3) | ((c == 2'h0) & ((4'h6 >> k) & 1'b1));
            end
            wr(`OFS_SHUTDOWN_SRC_EN, 8'h01 << s);
            wr(`OFS_SHUTDOWN_CTRL0, cw);
            fault <= 5'h01 << s;
            repeat (6) @(posedge pclk);
            rd(`OFS_SHUTDOWN_CTRL0, cw | 8'h80);
            ochk(en, lv);
            wr(`OFS_SHUTDOWN_CTRL0, cw);
            rd(`OFS_SHUTDOWN_CTRL0, cw | 8'h80);
            fault <= 0;
            repeat (6) @(posedge pclk);
            if (s == 4) begin
                rd(`OFS_SHUTDOWN_CTRL0, cw);
            end else begin
                rd(`OFS_SHUTDOWN_CTRL0, cw | 8'h80);
                wr(`OFS_SHUTDOWN_CTRL0, cw);
                rd(`OFS_SHUTDOWN_CTRL0, cw);
            end
            ochk(en, lv);
            wr(`OFS_SHUTDOWN_SRC_EN, 8'h00);
        end
        run <= 1;
        wedge(1'b1, 8);
        ochk(4'h0, 4'h9);
        $display("test shutdown done");
        wr(`OFS_POLARITY_CONTROL, 8'h00);
        wr(`OFS_STEERING, 8'h01);
        for (int k = 0; k < 15; k++) begin
            wr(`OFS_DATA_INPUT, 8'(k));
            code <= 4'(k);
            wedge(1'b1, 8);
            ochk(4'h0, {3'b000, k < 14});
            wedge(1'b0, 8);
            ochk(4'h0, 4'h0);
        end
        wr(`OFS_DATA_INPUT, 8'h03);
        code <= 3;
        wr(`OFS_POLARITY_CONTROL, 8'h02);
        wr(`OFS_STEERING, 8'h5A);
        wedge(1'b1, 8);
        ochk(4'h0, 4'hD);
        wedge(1'b0, 8);
        ochk(4'h0, 4'h7);
        for (int m = 2; m < 6; m++) begin
            wr(`OFS_MODE_CONTROL, 8'(8'h80 | m));
            wedge(1'b1, 8);
            ochk(4'h0, 4'h2);
        end
        wr(`OFS_POLARITY_CONTROL, 8'h00);
        wr(`OFS_STEERING, 8'h11);
        wr(`OFS_MODE_CONTROL, 8'h81);
        wedge(1'b0, 4);
        wr(`OFS_STEERING, 8'h10);
        repeat (3) @(posedge pclk);
        ochk(4'h0, 4'h0);
        wedge(1'b1, 8);
        wedge(1'b0, 8);
        ochk(4'h0, 4'h1);
        $display("test steering done");
        wr(`OFS_MODE_CONTROL, 8'h80);
        wr(`OFS_STEERING, 8'h01);
        meas(d0);
        chk(32'(d0 <= 6), 32'h1);
        for (int n = 1; n < 6; n += 4) begin
            wr(`OFS_RISE_DEADBAND, 8'(n));
            meas(d);
            chk(32'((d - d0 == n) || (d - d0 == n + 1)), 32'h1);
        end
        wr(`OFS_CLOCK_SOURCE, 8'h01);
        wr(`OFS_RISE_DEADBAND, 8'h03);
        meas(d);
        chk(32'((d - d0 >= 7) && (d - d0 <= 16)), 32'h1);
        $display("test dead-band done");
        wr(`OFS_MODE_CONTROL, 8'h00);
        repeat (4) @(posedge pclk);
        ochk(4'hF, 4'h0);
        wr(`OFS_SHUTDOWN_CTRL0, 8'hB8);
        repeat (4) @(posedge pclk);
        ochk(4'h0, 4'hA);
        rd(`OFS_SHUTDOWN_CTRL0, 8'hB8);
        $display("test disabled shutdown done");
        close_out();
    end
    // Watchdog on the whole run
    initial begin
        repeat (100000) @(posedge pclk);
        mismatches++;
        close_out();
    end
endmodule // waveform_gen_config_shutdown_test

bind waveform_gen_config_shutdown wavegen_chk u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .out_enable_n(out_enable_n));
